/* File: core/tt_io_defs.vh */
// Offsets, indices, reset values and field positions of the I/O page
`ifndef TT_IO_DEFS_VH
`define TT_IO_DEFS_VH
// I/O page offsets
`define TT_OFS_SYS     16'h0200
`define TT_OFS_STBY    16'h0202
`define TT_OFS_IFM     16'h0213
`define TT_OFS_BSTOP   16'h0251
`define TT_OFS_BSTART  16'h0252
`define TT_OFS_DM1     16'h0254
`define TT_OFS_DM2     16'h0255
`define TT_OFS_PRIO    16'h025a
`define TT_OFS_FB      16'h025b
// Register array indices
`define TT_IX_SYS      4'h0
`define TT_IX_STBY     4'h1
`define TT_IX_IFM      4'h2
`define TT_IX_BSTOP    4'h3
`define TT_IX_BSTART   4'h4
`define TT_IX_DM1      4'h5
`define TT_IX_DM2      4'h6
`define TT_IX_PRIO     4'h7
`define TT_IX_FB       4'h8
`define TT_IX_LAST     4'h8
`define TT_IX_NONE     4'hf
// Reset values
`define TT_RST_STBY    8'h00
`define TT_RST_IFM     8'h00
`define TT_RST_BSTOP   8'h07
`define TT_RST_BSTART  8'h00
`define TT_RST_DM1     8'h60
`define TT_RST_DM2     8'h0d
`define TT_RST_PRIO    8'h35
`define TT_RST_FB      8'h00
// Host subaddresses
`define TT_SUB_A       8'h01
`define TT_SUB_B       8'h02
// Field positions
`define TT_SYS_DIS_HI  7
`define TT_SYS_DIS_LO  2
`define TT_SYS_TEST    1
`define TT_SYS_BURN    0
`define TT_STBY_DIG    2
`define TT_STBY_AFE    1
`define TT_IFM_STBY    1
`define TT_DM1_FONT1   7
`define TT_DM1_OSDEN   6
`define TT_DM1_FLASH   5
`define TT_DM1_H13     4
`define TT_DM1_SCR_HI  3
`define TT_DM1_SCR_LO  0
`define TT_DM2_CSET    7
`define TT_DM2_SLOW    3
`define TT_DM2_OFS10   2
`define TT_DM2_OFS16   1
`define TT_DM2_H10     0
`define TT_PRIO_SH_HI  5
`define TT_PRIO_SH_LO  3
`define TT_PRIO_NO_HI  2
`define TT_PRIO_NO_LO  0
`define TT_FB_C4       7
`define TT_FB_C3       6
`define TT_FB_INV      4
// Scanline counts, thresholds and serial bits per byte
`define TT_CH_10       4'ha
`define TT_CH_13       4'hd
`define TT_CH_8        4'h8
`define TT_OFS_10      5'h0a
`define TT_OFS_16      5'h10
`define TT_OFS_8       5'h08
`define TT_FONT2_THR   8'h20
`define TT_I2C_BITS    4'h8
`endif

/* File: core/tt_i2c_slave.v */
// Byte-level two-wire serial slave with pin synchronisers
`timescale 1ns/1ps
`include "tt_io_defs.vh"
module tt_i2c_slave #(
    parameter [6:0] DEV_ADDR = 7'h11
) (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_ce,
    input  wire       i_scl,
    input  wire       i_sda,
    input  wire [7:0] i_rd_byte,
    output reg        o_sda_oe,
    output reg        o_wr_stb,
    output reg        o_first,
    output reg  [7:0] o_wr_byte,
    output reg        o_rd_stb
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ACKA = 3'h2;
    localparam [2:0] ST_WDAT = 3'h3;
    localparam [2:0] ST_ACKW = 3'h4;
    localparam [2:0] ST_RDAT = 3'h5;
    localparam [2:0] ST_ACKR = 3'h6;

    reg [1:0] scl_s_r;
    reg [1:0] sda_s_r;
    reg       scl_d_r;
    reg       sda_d_r;
    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg [7:0] sh_r;
    reg       rw_r;
    reg       nack_r;
    reg       first_r;

    wire scl   = scl_s_r[1];
    wire sda   = sda_s_r[1];
    wire start = scl & scl_d_r & sda_d_r & ~sda;
    wire stop  = scl & scl_d_r & ~sda_d_r & sda;
    wire rise  = scl & ~scl_d_r;
    wire fall  = ~scl & scl_d_r;

    always @(posedge i_clk) begin
        if (i_srst) begin
            scl_s_r   <= 2'h3;
            sda_s_r   <= 2'h3;
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
            state_r   <= ST_IDLE;
            cnt_r     <= 4'h0;
            sh_r      <= 8'h00;
            rw_r      <= 1'b0;
            nack_r    <= 1'b0;
            first_r   <= 1'b0;
            o_sda_oe  <= 1'b0;
            o_wr_stb  <= 1'b0;
            o_first   <= 1'b0;
            o_wr_byte <= 8'h00;
            o_rd_stb  <= 1'b0;
        end else if (i_ce) begin
            scl_s_r  <= {scl_s_r[0], i_scl};
            sda_s_r  <= {sda_s_r[0], i_sda};
            scl_d_r  <= scl;
            sda_d_r  <= sda;
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
            if (start) begin
                state_r  <= ST_ADDR;
                cnt_r    <= 4'h0;
                first_r  <= 1'b1;
                o_sda_oe <= 1'b0;
            end else if (stop) begin
                state_r  <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (rise) begin
                if (state_r == ST_ADDR || state_r == ST_WDAT) begin
                    sh_r  <= {sh_r[6:0], sda};
                    cnt_r <= cnt_r + 4'h1;
                end
                if (state_r == ST_ACKR)
                    nack_r <= sda;
            end else if (fall) begin
                case (state_r)
                    ST_ADDR: begin
                        if (cnt_r == `TT_I2C_BITS) begin
                            if (sh_r[7:1] == DEV_ADDR) begin
                                o_sda_oe <= 1'b1;
                                rw_r     <= sh_r[0];
                                state_r  <= ST_ACKA;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_WDAT: begin
                        if (cnt_r == `TT_I2C_BITS) begin
                            o_wr_byte <= sh_r;
                            o_first   <= first_r;
                            first_r   <= 1'b0;
                            o_wr_stb  <= 1'b1;
                            o_sda_oe  <= 1'b1;
                            state_r   <= ST_ACKW;
                        end
                    end
                    ST_ACKA, ST_ACKW, ST_ACKR: begin
                        if (state_r != ST_ACKR && !(state_r == ST_ACKA
                                                    && rw_r)) begin
                            o_sda_oe <= 1'b0;
                            cnt_r    <= 4'h0;
                            state_r  <= ST_WDAT;
                        end else if (state_r == ST_ACKR && nack_r) begin
                            o_sda_oe <= 1'b0;
                            state_r  <= ST_IDLE;
                        end else begin
                            sh_r     <= i_rd_byte;
                            o_sda_oe <= ~i_rd_byte[7];
                            o_rd_stb <= 1'b1;
                            cnt_r    <= 4'h1;
                            state_r  <= ST_RDAT;
                        end
                    end
                    ST_RDAT: begin
                        if (cnt_r == `TT_I2C_BITS) begin
                            o_sda_oe <= 1'b0;
                            state_r  <= ST_ACKR;
                        end else begin
                            o_sda_oe <= ~sh_r[6];
                            sh_r     <= {sh_r[6:0], 1'b0};
                            cnt_r    <= cnt_r + 4'h1;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: core/tt_io_regs.v */
// I/O control register bank reached by the serial host
// What this block does
// - Host reaches registers only via serial subaddresses
// - Write-only registers read back zero
// - Reset values loaded by initialisation before use
// - System control loads boot byte, then read/write
// - Test mode bit; burn-in needs test pin
// - Standby bits power off digital, analog
// - Interface standby only with digital power off
// - Blanking start position, resets to zero
// - Blanking stop resets seven; start not stop
// - Font select by bit 7 and code threshold
// - OSD enable and flash phase reset one
// - Scroll start line in mode 1 bits 3..0
// - Character height 10, 13 or 8 lines
// - Mode 2 bit 3 selects pixel clock
// - Font offset 10, 16 or 8 lines
// - Control codes select charset or colour
// - Shadow and normal priority codes
// - Fast-blank register read clears status
// - Fast-blank colour bits and invert
`timescale 1ns/1ps
`include "tt_io_defs.vh"
module tt_io_regs #(
    parameter [6:0] I2C_ADDR = 7'h11
) (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_ce,
    input  wire       i_scl,
    input  wire       i_sda_in,
    input  wire       i_test_pin,
    input  wire [7:0] i_boot_byte,
    input  wire       i_frame_start,
    input  wire [7:0] i_char_code,
    input  wire       i_fb_event,
    output reg        o_sda_out,
    output wire       o_sda_oe,
    output reg        o_init_done,
    output reg  [5:0] o_unit_dis,
    output reg        o_test_mode,
    output reg        o_burnin,
    output reg        o_dig_power_off,
    output reg        o_afe_power_off,
    output reg        o_if_standby,
    output reg  [7:0] o_blank_start,
    output reg  [7:0] o_blank_stop,
    output reg        o_osd_font1_only,
    output reg        o_osd_en,
    output reg        o_osd_flash_phase,
    output reg  [3:0] o_scroll_line,
    output reg  [3:0] o_char_height,
    output reg        o_pix_clk_slow,
    output reg  [4:0] o_font_offset,
    output reg        o_ctrl_code_charset,
    output reg  [2:0] o_prio_shadow,
    output reg  [2:0] o_prio_normal,
    output reg  [1:0] o_osd_colour_hi,
    output reg        o_colour_invert,
    output reg        o_font2_sel
);
    localparam       NREG    = 9;
    localparam [0:0] ST_INIT = 1'b0;
    localparam [0:0] ST_RUN  = 1'b1;

    // ****************************************************
    // Decoding
    // ****************************************************
    function [3:0] reg_index;
        input [15:0] ofs;
        begin
            case (ofs)
                `TT_OFS_SYS:    reg_index = `TT_IX_SYS;
                `TT_OFS_STBY:   reg_index = `TT_IX_STBY;
                `TT_OFS_IFM:    reg_index = `TT_IX_IFM;
                `TT_OFS_BSTOP:  reg_index = `TT_IX_BSTOP;
                `TT_OFS_BSTART: reg_index = `TT_IX_BSTART;
                `TT_OFS_DM1:    reg_index = `TT_IX_DM1;
                `TT_OFS_DM2:    reg_index = `TT_IX_DM2;
                `TT_OFS_PRIO:   reg_index = `TT_IX_PRIO;
                `TT_OFS_FB:     reg_index = `TT_IX_FB;
                default:        reg_index = `TT_IX_NONE;
            endcase
        end
    endfunction

    function [7:0] rst_val;
        input [3:0] ix;
        input [7:0] boot;
        begin
            case (ix)
                `TT_IX_SYS:    rst_val = boot;
                `TT_IX_STBY:   rst_val = `TT_RST_STBY;
                `TT_IX_IFM:    rst_val = `TT_RST_IFM;
                `TT_IX_BSTOP:  rst_val = `TT_RST_BSTOP;
                `TT_IX_BSTART: rst_val = `TT_RST_BSTART;
                `TT_IX_DM1:    rst_val = `TT_RST_DM1;
                `TT_IX_DM2:    rst_val = `TT_RST_DM2;
                `TT_IX_PRIO:   rst_val = `TT_RST_PRIO;
                default:       rst_val = `TT_RST_FB;
            endcase
        end
    endfunction

    // ****************************************************
    // Storage and serial slave
    // ****************************************************
    reg  [7:0]  regs_r [0:NREG-1];
    reg  [0:0]  state_r;
    reg  [3:0]  init_ix_r;
    reg         first_run_r;
    reg  [7:0]  sub_r;
    reg  [1:0]  sidx_r;
    reg  [15:0] ptr_r;
    reg  [7:0]  rd_byte_r;
    reg         fb_stat_r;
    reg  [1:0]  test_s_r;
    integer     k;

    wire        wr_stb;
    wire        wr_first;
    wire [7:0]  wr_byte;
    wire        rd_stb;
    wire [3:0]  ptr_ix = reg_index(ptr_r);
    wire [7:0]  sys    = regs_r[`TT_IX_SYS];
    wire [7:0]  stby   = regs_r[`TT_IX_STBY];
    wire [7:0]  ifm    = regs_r[`TT_IX_IFM];
    wire [7:0]  dm1    = regs_r[`TT_IX_DM1];
    wire [7:0]  dm2    = regs_r[`TT_IX_DM2];
    wire [7:0]  prio   = regs_r[`TT_IX_PRIO];
    wire [7:0]  fb     = regs_r[`TT_IX_FB];
    wire        upd    = i_frame_start | first_run_r |
                         (state_r == ST_INIT);

    tt_i2c_slave #(
        .DEV_ADDR (I2C_ADDR)
    ) u_slave (
        .i_clk     (i_clk),
        .i_srst    (i_srst),
        .i_ce      (i_ce),
        .i_scl     (i_scl),
        .i_sda     (i_sda_in),
        .i_rd_byte (rd_byte_r),
        .o_sda_oe  (o_sda_oe),
        .o_wr_stb  (wr_stb),
        .o_first   (wr_first),
        .o_wr_byte (wr_byte),
        .o_rd_stb  (rd_stb)
    );

    // ****************************************************
    // Initialisation and host writes
    // ****************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            for (k = 0; k < NREG; k = k + 1)
                regs_r[k] <= 8'h00;
            state_r     <= ST_INIT;
            init_ix_r   <= `TT_IX_SYS;
            first_run_r <= 1'b0;
            o_init_done <= 1'b0;
            sub_r       <= 8'h00;
            sidx_r      <= 2'h0;
            ptr_r       <= 16'h0000;
        end else if (i_ce) begin
            first_run_r <= 1'b0;
            case (state_r)
                ST_INIT: begin
                    regs_r[init_ix_r] <= rst_val(init_ix_r,
                                                 i_boot_byte);
                    init_ix_r <= init_ix_r + 4'h1;
                    if (init_ix_r == `TT_IX_LAST) begin
                        state_r     <= ST_RUN;
                        first_run_r <= 1'b1;
                        o_init_done <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (wr_stb) begin
                        if (wr_first) begin
                            sub_r  <= wr_byte;
                            sidx_r <= 2'h0;
                        end else if (sub_r == `TT_SUB_A) begin
                            if (sidx_r == 2'h0)
                                ptr_r[15:8] <= wr_byte;
                            else if (sidx_r == 2'h1)
                                ptr_r[7:0] <= wr_byte;
                            if (sidx_r != 2'h2)
                                sidx_r <= sidx_r + 2'h1;
                        end else if (sub_r == `TT_SUB_B &&
                                     ptr_ix != `TT_IX_NONE) begin
                            regs_r[ptr_ix] <= wr_byte;
                        end
                    end
                end
                default: state_r <= ST_INIT;
            endcase
        end
    end

    // ****************************************************
    // Readback and fast-blank status
    // ****************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            rd_byte_r <= 8'h00;
            fb_stat_r <= 1'b0;
            test_s_r  <= 2'h0;
        end else if (i_ce) begin
            test_s_r  <= {test_s_r[0], i_test_pin};
            fb_stat_r <= i_fb_event |
                         (fb_stat_r &
                          ~(rd_stb && ptr_ix == `TT_IX_FB));
            case (ptr_ix)
                `TT_IX_SYS:
                    rd_byte_r <= {sys[`TT_SYS_DIS_HI:`TT_SYS_TEST],
                                  o_burnin};
                `TT_IX_FB:
                    rd_byte_r <= {7'h00, fb_stat_r};
                default:
                    rd_byte_r <= 8'h00;
            endcase
        end
    end

    // ****************************************************
    // System, power and test controls
    // ****************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_sda_out       <= 1'b0;
            o_unit_dis      <= 6'h00;
            o_test_mode     <= 1'b0;
            o_burnin        <= 1'b0;
            o_dig_power_off <= 1'b0;
            o_afe_power_off <= 1'b0;
            o_if_standby    <= 1'b0;
            o_font2_sel     <= 1'b0;
        end else if (i_ce) begin
            o_unit_dis      <= sys[`TT_SYS_DIS_HI:`TT_SYS_DIS_LO];
            o_test_mode     <= sys[`TT_SYS_TEST];
            o_burnin        <= sys[`TT_SYS_BURN] & test_s_r[1];
            o_dig_power_off <= stby[`TT_STBY_DIG];
            o_afe_power_off <= stby[`TT_STBY_AFE];
            o_if_standby    <= ifm[`TT_IFM_STBY] &
                               stby[`TT_STBY_DIG];
            o_font2_sel     <= ~o_osd_font1_only &
                               (i_char_code >= `TT_FONT2_THR);
        end
    end

    // ****************************************************
    // Display settings, taken over at frame start
    // ****************************************************
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_blank_start       <= `TT_RST_BSTART;
            o_blank_stop        <= `TT_RST_BSTOP;
            o_osd_font1_only    <= 1'b0;
            o_osd_en            <= 1'b1;
            o_osd_flash_phase   <= 1'b1;
            o_scroll_line       <= 4'h0;
            o_char_height       <= `TT_CH_10;
            o_pix_clk_slow      <= 1'b1;
            o_font_offset       <= `TT_OFS_10;
            o_ctrl_code_charset <= 1'b0;
            o_prio_shadow       <= 3'h6;
            o_prio_normal       <= 3'h5;
            o_osd_colour_hi     <= 2'h0;
            o_colour_invert     <= 1'b0;
        end else if (i_ce && upd) begin
            o_blank_start     <= regs_r[`TT_IX_BSTART];
            o_blank_stop      <= regs_r[`TT_IX_BSTOP];
            o_osd_font1_only  <= dm1[`TT_DM1_FONT1];
            o_osd_en          <= dm1[`TT_DM1_OSDEN];
            o_osd_flash_phase <= dm1[`TT_DM1_FLASH];
            o_scroll_line     <= dm1[`TT_DM1_SCR_HI:`TT_DM1_SCR_LO];
            if (dm2[`TT_DM2_H10])
                o_char_height <= `TT_CH_10;
            else if (dm1[`TT_DM1_H13])
                o_char_height <= `TT_CH_13;
            else
                o_char_height <= `TT_CH_8;
            o_pix_clk_slow <= dm2[`TT_DM2_SLOW];
            if (dm2[`TT_DM2_OFS10])
                o_font_offset <= `TT_OFS_10;
            else if (dm2[`TT_DM2_OFS16])
                o_font_offset <= `TT_OFS_16;
            else
                o_font_offset <= `TT_OFS_8;
            o_ctrl_code_charset <= dm2[`TT_DM2_CSET];
            o_prio_shadow <= prio[`TT_PRIO_SH_HI:`TT_PRIO_SH_LO];
            o_prio_normal <= prio[`TT_PRIO_NO_HI:`TT_PRIO_NO_LO];
            o_osd_colour_hi <= {fb[`TT_FB_C4], fb[`TT_FB_C3]};
            o_colour_invert <= fb[`TT_FB_INV];
        end
    end
endmodule

/* File: dv/tt_io_regs_sva.sv */
// Concurrent checks on the ports of the I/O control register bank
`timescale 1ns/1ps
module tt_io_regs_sva (
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic       i_ce,
    input wire logic       i_scl,
    input wire logic       i_test_pin,
    input wire logic       i_frame_start,
    input wire logic [7:0] i_char_code,
    input wire logic       o_sda_oe,
    input wire logic       o_init_done,
    input wire logic       o_burnin,
    input wire logic       o_dig_power_off,
    input wire logic       o_if_standby,
    input wire logic [7:0] o_blank_start,
    input wire logic [7:0] o_blank_stop,
    input wire logic       o_osd_font1_only,
    input wire logic [3:0] o_char_height,
    input wire logic [4:0] o_font_offset,
    input wire logic [2:0] o_prio_shadow,
    input wire logic [2:0] o_prio_normal,
    input wire logic       o_font2_sel
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // ********
    // Port relations
    // ********
    property p_burnin_pin; (!i_test_pin) [*5] |-> !o_burnin; endproperty
    a_burnin_pin: assert property (p_burnin_pin)
        else $error("burn-in on with test pin low");
    property p_if_stby; o_if_standby |-> o_dig_power_off; endproperty
    a_if_stby: assert property (p_if_stby)
        else $error("interface standby without digital power off");
    property p_frame_hold;
        $past(o_init_done, 3) && !$past(i_frame_start)
            && !$past(i_frame_start, 2) |-> $stable({o_blank_start,
            o_blank_stop, o_prio_shadow, o_char_height});
    endproperty
    a_frame_hold: assert property (p_frame_hold)
        else $error("display setting changed outside frame start");
    property p_font2;
        !$past(i_srst) && $past(i_ce) |-> o_font2_sel ==
            $past(!o_osd_font1_only && i_char_code >= 8'h20);
    endproperty
    a_font2: assert property (p_font2)
        else $error("second font select wrong");
    property p_rst_vals;
        $past(i_srst) |-> o_blank_stop == 8'h07 && o_blank_start == 8'h00
            && o_prio_shadow == 3'h6 && o_prio_normal == 3'h5 && !o_init_done;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("reset values wrong");
    property p_init_len;
        $rose(o_init_done) |-> !$past(i_srst, 8) && ($past(i_srst, 9)
            || $past(i_srst, 10) || $past(i_srst, 11));
    endproperty
    a_init_len: assert property (p_init_len)
        else $error("init length wrong");
    property p_sizes;
        o_init_done |-> o_char_height inside {4'h8, 4'ha, 4'hd}
            && o_font_offset inside {5'h08, 5'h0a, 5'h10};
    endproperty
    a_sizes: assert property (p_sizes)
        else $error("height or font offset out of set");
    property p_sda_scl; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_sda_scl: assert property (p_sda_scl)
        else $error("data line changed with serial clock high");
endmodule
bind tt_io_regs tt_io_regs_sva u_sva (.*);

/* File: dv/tt_io_host.sv */
// Serial bus host model that reaches the register bank over two wires
`timescale 1ns/1ps
`include "tt_io_defs.vh"
module tt_io_host #(
    parameter logic [6:0] ADDR = 7'h11
) (
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    localparam realtime Q = 31.25;
    int   nak_cnt = 0;
    logic last_nak, r;
    initial {o_scl, o_sda_oe} = 2'b10;
    // ********
    // Bits, bytes and transfers; the clock stands high between frames
    // ********
    task automatic bitx(input logic b);
        #Q o_sda_oe = !b;
        #Q o_scl = 1'b1;
        #Q r = i_sda;
        #Q o_scl = 1'b0;
    endtask
    task automatic start;
        #Q o_sda_oe = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b1;
        #Q o_scl = 1'b0;
    endtask
    task automatic stop;
        #Q o_sda_oe = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b0;
        #Q;
    endtask
    task automatic wbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) bitx(b[i]);
        bitx(1'b1);
        last_nak = r;
        nak_cnt += r;
    endtask
    task automatic rbyte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1);
            b[i] = r;
        end
        bitx(1'b1);
    endtask
    task automatic point(input logic [15:0] p);
        start;
        wbyte({ADDR, 1'b0});
        wbyte(`TT_SUB_A);
        wbyte(p[15:8]);
        wbyte(p[7:0]);
        stop;
    endtask
    task automatic write(input logic [15:0] p, input logic [7:0] d);
        point(p);
        start;
        wbyte({ADDR, 1'b0});
        wbyte(`TT_SUB_B);
        wbyte(d);
        stop;
    endtask
    task automatic read(input logic [15:0] p, output logic [7:0] d);
        point(p);
        start;
        wbyte({ADDR, 1'b1});
        rbyte(d);
        stop;
    endtask
    task automatic probe(input logic [7:0] a);
        start;
        wbyte(a);
        stop;
    endtask
endmodule

/* File: dv/tt_io_regs_tb.sv */
// Self-checking bench of the I/O control register bank
`timescale 1ns/1ps
`include "tt_io_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    error_cnt++; $display("unexpected %0t got %h exp %h", $time, g, e); \
    end end
module tt_io_regs_tb;
    localparam int LIMIT = 90000;
    logic        i_clk, i_srst, i_ce, i_test_pin, i_frame_start, i_fb_event;
    logic [7:0]  i_boot_byte, i_char_code, sys, sb, ifm, rd;
    wire         i_scl, i_sda_in, host_oe, o_sda_out, o_sda_oe, o_init_done;
    wire         o_test_mode, o_burnin, o_dig_power_off, o_afe_power_off;
    wire         o_if_standby, o_osd_font1_only, o_osd_en, o_osd_flash_phase;
    wire         o_pix_clk_slow, o_ctrl_code_charset, o_colour_invert;
    wire         o_font2_sel;
    wire [5:0]   o_unit_dis;
    wire [7:0]   o_blank_start, o_blank_stop;
    wire [3:0]   o_scroll_line, o_char_height;
    wire [4:0]   o_font_offset;
    wire [2:0]   o_prio_shadow, o_prio_normal;
    wire [1:0]   o_osd_colour_hi;
    int          error_cnt, check_count, cyc, it, w;
    logic [31:0] seed;
    logic [47:0] cfg, old;
    logic [2:0]  tbl [5] = '{3'b001, 3'b000, 3'b010, 3'b100, 3'b110};
    assign i_sda_in = ~(host_oe | o_sda_oe);
    tt_io_regs u_tt_io_regs (.*);
    tt_io_host u_host (.i_sda(i_sda_in), .o_scl(i_scl), .o_sda_oe(host_oe));
    // ********
    // Helpers
    // ********
    function automatic [7:0] rnd;
        rnd = 8'($random(seed));
    endfunction
    function automatic [3:0] exp_h(input [7:0] d1, input [7:0] d2);
        exp_h = d2[0] ? 4'ha : (d1[4] ? 4'hd : 4'h8);
    endfunction
    function automatic [4:0] exp_o(input [7:0] d2);
        exp_o = d2[2] ? 5'h0a : (d2[1] ? 5'h10 : 5'h08);
    endfunction
    task automatic tick;
        @(posedge i_clk) #1;
    endtask
    task automatic chk_disp(input [47:0] c);
        `CHK(o_blank_start, c[15:8])
        `CHK(o_blank_stop, c[7:0])
        `CHK({o_osd_font1_only, o_osd_en, o_osd_flash_phase}, c[47:45])
        `CHK(o_scroll_line, c[43:40])
        `CHK(o_char_height, exp_h(c[47:40], c[39:32]))
        `CHK({o_ctrl_code_charset, o_pix_clk_slow}, {c[39], c[35]})
        `CHK(o_font_offset, exp_o(c[39:32]))
        `CHK({o_prio_shadow, o_prio_normal}, c[29:24])
        `CHK({o_osd_colour_hi, o_colour_invert}, {c[23:22], c[20]})
    endtask
    task automatic chk_imm(input [7:0] s, input [7:0] b, input [7:0] f);
        `CHK({o_unit_dis, o_test_mode}, s[7:1])
        `CHK(o_burnin, s[0] & i_test_pin)
        `CHK({o_dig_power_off, o_afe_power_off}, b[2:1])
        `CHK(o_if_standby, f[1] & b[2])
        `CHK(o_sda_out, 1'b0)
        u_host.read(`TT_OFS_SYS, rd);
        `CHK(rd, {s[7:1], s[0] & i_test_pin})
    endtask
    task automatic do_reset;
        i_srst = 1'b1;
        repeat (3) @(posedge i_clk);
        #1 i_srst = 1'b0;
        for (w = 0; w < 40 && o_init_done !== 1'b1; w++) tick;
        `CHK(o_init_done, 1'b1)
        repeat (3) tick;
        chk_disp(48'h600d_3500_0007);
        chk_imm(i_boot_byte, 8'h00, 8'h00);
    endtask
    task automatic results;
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ********
    // Stimulus
    // ********
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        i_char_code <= #1 rnd();
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            results;
        end
    end
    initial begin
        seed = 32'hc8760982;
        {i_srst, i_ce, i_test_pin, i_frame_start, i_fb_event} = 5'h1c;
        i_boot_byte = rnd() & 8'hfb;
        do_reset;
        old = 48'h600d_3500_0007;
        for (it = 0; it < 5; it++) begin
            i_test_pin = rnd() & 8'h01;
            sys = rnd() & 8'hfb;
            sb = rnd() & 8'h06;
            ifm = rnd() & 8'h02;
            if (it == 1) {sb[2], ifm[1]} = 2'b11;
            cfg = {rnd(), rnd() & 8'h88 | tbl[it], rnd() & 8'h3f,
                   rnd() & 8'hd0, rnd(), 8'h00};
            cfg[44] = it[0];
            cfg[7:0] = cfg[15:8] + 8'h01 + (rnd() & 8'h0f);
            u_host.write(`TT_OFS_SYS, sys);
            u_host.write(`TT_OFS_STBY, sb);
            u_host.write(`TT_OFS_IFM, ifm);
            u_host.write(`TT_OFS_DM1, cfg[47:40]);
            u_host.write(`TT_OFS_DM2, cfg[39:32]);
            u_host.write(`TT_OFS_PRIO, cfg[31:24]);
            u_host.write(`TT_OFS_FB, cfg[23:16]);
            u_host.write(`TT_OFS_BSTART, cfg[15:8]);
            u_host.write(`TT_OFS_BSTOP, cfg[7:0]);
            tick;
            chk_disp(old);
            chk_imm(sys, sb, ifm);
            tick;
            i_ce = 1'b0;
            i_frame_start = 1'b1;
            tick;
            chk_disp(old);
            i_ce = 1'b1;
            tick;
            i_frame_start = 1'b0;
            repeat (2) tick;
            chk_disp(cfg);
            old = cfg;
        end
        i_fb_event = 1'b1;
        tick;
        i_fb_event = 1'b0;
        u_host.read(`TT_OFS_FB, rd);
        `CHK(rd, 8'h01)
        u_host.read(`TT_OFS_FB, rd);
        `CHK(rd, 8'h00)
        u_host.read(`TT_OFS_DM1, rd);
        `CHK(rd, 8'h00)
        u_host.read(16'h0300, rd);
        `CHK(rd, 8'h00)
        `CHK(u_host.nak_cnt, 0)
        u_host.probe(8'h24);
        `CHK(u_host.last_nak, 1'b1)
        tick;
        i_boot_byte = rnd() & 8'hfb;
        do_reset;
        results;
    end
endmodule
